// File: time_update_irq_consts.vh
// Constants for the time update interrupt block
`ifndef TIME_UPDATE_IRQ_CONSTS_VH
`define TIME_UPDATE_IRQ_CONSTS_VH

// Clock and timing
`define CLK_PERIOD_NS        25
`define SECOND_NS            1000000000
`define IRQ_PULSE_TIME_NS    7182500
`define SECOND_CYCLES        (`SECOND_NS / `CLK_PERIOD_NS)
`define IRQ_PULSE_CYCLES     (`IRQ_PULSE_TIME_NS / `CLK_PERIOD_NS)
`define SECONDS_PER_MINUTE   6'h3C

// Register indices; byte address is four times the index
`define IDX_EXTENSION_CONTROL 8'h0D
`define IDX_EVENT_FLAGS       8'h0E
`define IDX_INTERRUPT_CONTROL 8'h0F
`define IDX_IRQ_STATUS        8'h10
`define IDX_IRQ_MASK          8'h11

// Extension control fields
`define EXT_UPDATE_SEL_BIT   5
`define EXT_RESET_VAL        8'h00

// Event flag fields
`define FLG_UPDATE_BIT       5

// Interrupt control fields
`define CTL_UPDATE_IE_BIT    5
`define CTL_SW_RESET_BIT     0
`define CTL_WRITE_MASK       8'hFD
`define CTL_RESET_VAL        8'h00

// Block interrupt status and mask fields
`define IST_UPDATE_BIT       0
`define IST_PULSE_END_BIT    1
`define IST_WIDTH            2
`define IST_RESET_VAL        2'h0
`define IMASK_RESET_VAL      2'h0

// AHB encodings
`define HTRANS_NONSEQ_BIT    1
`define HRESP_OKAY           1'h0

`endif

// File: time_update_irq.v
// Time update interrupt block with AHB-Lite register slave
//
// What this block does
// [R1] Raise update event at second or minute boundary
// [R2] Select bit: 0 seconds, 1 minutes; readable
// [R3] Every update event sets the update flag
// [R4] Flag stays set until host writes zero
// [R5] Writing one to the flag is ignored
// [R6] Pull pin low only when enable is set
// [R7] Release low level after fixed pulse time
// [R8] Next event pulls low again if enabled
// [R9] Clearing flag releases the low level immediately
// [R10] Clearing enable releases the low level immediately
// [R11] Software reset bit suppresses all update events
// [R12] Clearing the enable bit cannot switch off event generation
// [R13] Other sources may still drive the pin
// [R14] Host clears enable before changing settings
// [R15] Protected bits ignore writes, read zero
// [R16] Pin is open drain, low when requested
`timescale 1ns/1ps
`include "time_update_irq_consts.vh"

module time_update_irq #(
    parameter SECOND_CYCLES    = `SECOND_CYCLES,
    parameter IRQ_PULSE_CYCLES = `IRQ_PULSE_CYCLES
) (
    input  wire        clk,
    input  wire        reset_n,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output wire [31:0] hrdata,
    input  wire        other_irq_req,
    output wire        int_out,
    output wire        int_oe,
    output wire        irq
);

    // Timekeeping chain
    reg  [25:0] prescale_r;
    reg  [5:0]  second_r;
    wire        second_tick;
    wire        minute_tick;
    wire        update_event;

    // Registers
    reg  [7:0]  ext_ctrl_r;
    reg  [7:0]  int_ctrl_r;
    reg         update_flag_r;
    reg  [`IST_WIDTH-1:0] irq_status_r;
    reg  [`IST_WIDTH-1:0] irq_mask_r;

    // Pulse generator
    reg  [18:0] pulse_cnt_r;
    reg         pulse_active_r;
    reg         int_oe_r;

    // Bus slave state
    reg         dphase_r;
    reg         dwrite_r;
    reg  [7:0]  didx_r;
    reg         hreadyout_r;
    reg  [31:0] hrdata_r;

    wire        sw_reset;
    wire        update_sel;
    wire        update_ie;
    wire        addr_accept;
    wire        wr_commit;
    wire        wr_ext;
    wire        wr_flags;
    wire        wr_ctrl;
    wire        wr_status;
    wire        wr_mask;
    wire        flag_clear;
    wire        update_flag_nxt;
    wire        update_ie_nxt;
    wire        pulse_expired;
    wire        pulse_end;
    reg         pulse_active_nxt;
    reg  [18:0] pulse_cnt_nxt;
    reg  [31:0] rdata_nxt;

    assign sw_reset   = int_ctrl_r[`CTL_SW_RESET_BIT];
    assign update_sel = ext_ctrl_r[`EXT_UPDATE_SEL_BIT];
    assign update_ie  = int_ctrl_r[`CTL_UPDATE_IE_BIT];

    // ------------------------------------------------------------------
    // Timekeeping: one-cycle tick per second, seconds counted to a minute
    // ------------------------------------------------------------------
    assign second_tick = (prescale_r == SECOND_CYCLES - 1);
    assign minute_tick = second_tick && (second_r == `SECONDS_PER_MINUTE - 6'h01);

    // Chain held cleared while software reset is set, so no boundary occurs
    always @(posedge clk) begin
        if (!reset_n || sw_reset) begin // [R11]
            prescale_r <= 26'h0000000;
            second_r   <= 6'h00;
        end else if (second_tick) begin
            prescale_r <= 26'h0000000;
            if (second_r == `SECONDS_PER_MINUTE - 6'h01) begin
                second_r <= 6'h00;
            end else begin
                second_r <= second_r + 6'h01;
            end
        end else begin
            prescale_r <= prescale_r + 26'h0000001;
        end
    end

    // Event fires regardless of enable; the enable only gates the pin
    assign update_event = !sw_reset && (update_sel ? minute_tick : second_tick); // [R1] [R2] [R12] [R11]

    // ------------------------------------------------------------------
    // AHB-Lite slave: one wait state, then data phase completes
    // ------------------------------------------------------------------
    assign addr_accept = hsel && htrans[`HTRANS_NONSEQ_BIT] && hready;
    assign wr_commit   = dphase_r && dwrite_r;

    always @(posedge clk) begin
        if (!reset_n) begin
            dphase_r    <= 1'b0;
            dwrite_r    <= 1'b0;
            didx_r      <= 8'h00;
            hreadyout_r <= 1'b1;
        end else if (dphase_r) begin
            dphase_r    <= 1'b0;
            hreadyout_r <= 1'b1;
        end else if (addr_accept) begin
            dphase_r    <= 1'b1;
            dwrite_r    <= hwrite;
            didx_r      <= haddr[9:2];
            hreadyout_r <= 1'b0;
        end
    end

    // Whole-word registers only; unmapped words read zero, writes dropped
    assign wr_ext    = wr_commit && (didx_r == `IDX_EXTENSION_CONTROL);
    assign wr_flags  = wr_commit && (didx_r == `IDX_EVENT_FLAGS);
    assign wr_ctrl   = wr_commit && (didx_r == `IDX_INTERRUPT_CONTROL);
    assign wr_status = wr_commit && (didx_r == `IDX_IRQ_STATUS);
    assign wr_mask   = wr_commit && (didx_r == `IDX_IRQ_MASK);

    assign hreadyout = hreadyout_r;
    assign hresp     = `HRESP_OKAY;
    assign hrdata    = hrdata_r;

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (!reset_n) begin
            ext_ctrl_r <= `EXT_RESET_VAL;
            int_ctrl_r <= `CTL_RESET_VAL;
            irq_mask_r <= `IMASK_RESET_VAL;
        end else begin
            if (wr_ext) begin
                ext_ctrl_r <= hwdata[7:0]; // [R2]
            end
            if (wr_ctrl) begin
                int_ctrl_r <= hwdata[7:0] & `CTL_WRITE_MASK; // [R15]
            end
            if (wr_mask) begin
                irq_mask_r <= hwdata[`IST_WIDTH-1:0];
            end
        end
    end

    // Only a written zero clears; a written one has no effect
    assign flag_clear      = wr_flags && !hwdata[`FLG_UPDATE_BIT]; // [R4] [R5]
    // Set beats a clear landing in the same cycle
    assign update_flag_nxt = update_event ? 1'b1 : (flag_clear ? 1'b0 : update_flag_r); // [R3] [R4]
    assign update_ie_nxt   = wr_ctrl ? hwdata[`CTL_UPDATE_IE_BIT] : update_ie;

    always @(posedge clk) begin
        if (!reset_n) begin
            update_flag_r <= 1'b0;
        end else begin
            update_flag_r <= update_flag_nxt; // [R3]
        end
    end

    // ------------------------------------------------------------------
    // Pin pulse: loads on an enabled event, ends on timeout or cancel
    // ------------------------------------------------------------------
    assign pulse_expired = pulse_active_r && (pulse_cnt_r == 19'h00001);

    always @* begin
        pulse_active_nxt = pulse_active_r;
        pulse_cnt_nxt    = pulse_cnt_r;
        if (update_event && update_ie) begin
            // Restarts even if flag was never cleared
            pulse_active_nxt = 1'b1; // [R6] [R8]
            pulse_cnt_nxt    = IRQ_PULSE_CYCLES[18:0];
        end else if (pulse_active_r) begin
            if (pulse_expired) begin
                pulse_active_nxt = 1'b0; // [R7]
                pulse_cnt_nxt    = 19'h00000;
            end else begin
                pulse_cnt_nxt = pulse_cnt_r - 19'h00001;
            end
        end
        // Cancels act on the register value written this cycle
        if (!update_ie_nxt) begin
            pulse_active_nxt = 1'b0; // [R10]
            pulse_cnt_nxt    = 19'h00000;
        end else if (update_flag_r && !update_flag_nxt) begin
            pulse_active_nxt = 1'b0; // [R9]
            pulse_cnt_nxt    = 19'h00000;
        end
    end

    always @(posedge clk) begin
        if (!reset_n) begin
            pulse_active_r <= 1'b0;
            pulse_cnt_r    <= 19'h00000;
        end else begin
            pulse_active_r <= pulse_active_nxt;
            pulse_cnt_r    <= pulse_cnt_nxt;
        end
    end

    // Shared pin: this source or any other source pulls it low
    always @(posedge clk) begin
        if (!reset_n) begin
            int_oe_r <= 1'b0;
        end else begin
            int_oe_r <= pulse_active_nxt || other_irq_req; // [R13] [R16]
        end
    end

    assign int_out = 1'b0; // [R16]
    assign int_oe  = int_oe_r;

    // ------------------------------------------------------------------
    // Block interrupt: sticky status, write one to clear, set wins
    // ------------------------------------------------------------------
    assign pulse_end = pulse_expired && !(update_event && update_ie);

    always @(posedge clk) begin
        if (!reset_n) begin
            irq_status_r <= `IST_RESET_VAL;
        end else begin
            irq_status_r[`IST_UPDATE_BIT] <= update_event ||
                (irq_status_r[`IST_UPDATE_BIT] && !(wr_status && hwdata[`IST_UPDATE_BIT]));
            irq_status_r[`IST_PULSE_END_BIT] <= pulse_end ||
                (irq_status_r[`IST_PULSE_END_BIT] && !(wr_status && hwdata[`IST_PULSE_END_BIT]));
        end
    end

    assign irq = |(irq_status_r & irq_mask_r);

    // ------------------------------------------------------------------
    // Read mux; protected bits and absent sources read zero
    // ------------------------------------------------------------------
    always @* begin
        rdata_nxt = 32'h00000000;
        if (didx_r == `IDX_EXTENSION_CONTROL) begin
            rdata_nxt[7:0] = ext_ctrl_r;
        end else if (didx_r == `IDX_EVENT_FLAGS) begin
            rdata_nxt[`FLG_UPDATE_BIT] = update_flag_r; // [R4] [R15]
        end else if (didx_r == `IDX_INTERRUPT_CONTROL) begin
            rdata_nxt[7:0] = int_ctrl_r; // [R15]
        end else if (didx_r == `IDX_IRQ_STATUS) begin
            rdata_nxt[`IST_WIDTH-1:0] = irq_status_r;
        end else if (didx_r == `IDX_IRQ_MASK) begin
            rdata_nxt[`IST_WIDTH-1:0] = irq_mask_r;
        end
    end

    always @(posedge clk) begin
        if (!reset_n) begin
            hrdata_r <= 32'h00000000;
        end else if (dphase_r && !dwrite_r) begin
            hrdata_r <= rdata_nxt;
        end
    end

    // Size is not checked: only whole-word transfers are supported
    wire unused_ok = &{1'b0, hsize, haddr[31:10], haddr[1:0], hwdata[31:8]};

endmodule

// File: time_update_irq_sva.sv
// Port checker for the time update interrupt block
`timescale 1ns/1ps
`include "time_update_irq_consts.vh"
module time_update_irq_sva #(
    parameter IRQ_PULSE_CYCLES = 5
) (
    input wire        clk,
    input wire        reset_n,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire        hreadyout,
    input wire        hresp,
    input wire [31:0] hrdata,
    input wire        other_irq_req,
    input wire        int_out,
    input wire        int_oe
);
    reg  [31:0] run_r;
    reg         ctl_wr_r;
    wire        take = hsel && htrans[1] && hready;
    always @(posedge clk) begin
        if (!reset_n) begin
            run_r    <= 32'h0;
            ctl_wr_r <= 1'b0;
        end else begin
            // Low time owed to the other source is not counted
            run_r    <= (int_oe && !other_irq_req && !$past(other_irq_req)) ? run_r + 32'h1 : 32'h0;
            ctl_wr_r <= take && hwrite && haddr[9:2] == `IDX_INTERRUPT_CONTROL;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_okay; hresp == `HRESP_OKAY; endproperty
    property p_wait; take |=> !hreadyout ##1 hreadyout; endproperty
    property p_one; !hreadyout |=> hreadyout; endproperty
    property p_hold; hreadyout && $past(hreadyout) |-> $stable(hrdata); endproperty
    property p_pulse; run_r <= IRQ_PULSE_CYCLES; endproperty
    property p_other; other_irq_req |=> int_oe; endproperty
    property p_drive; int_out == 1'b0; endproperty
    property p_cancel;
        ctl_wr_r && !hreadyout && !hwdata[`CTL_UPDATE_IE_BIT] && !other_irq_req |=> !int_oe;
    endproperty
    a_okay: assert property (p_okay) else $error("hresp not okay");
    a_wait: assert property (p_wait) else $error("wait state wrong");
    a_one: assert property (p_one) else $error("ready low too long");
    a_hold: assert property (p_hold) else $error("read data moved");
    a_pulse: assert property (p_pulse) else $error("pulse too long");
    a_other: assert property (p_other) else $error("other source lost");
    a_drive: assert property (p_drive) else $error("pin driven high");
    a_cancel: assert property (p_cancel) else $error("enable clear kept pin low");
    c_pulse: cover property ($rose(int_oe));
    c_cancel: cover property (ctl_wr_r && !hreadyout);
    c_other: cover property (other_irq_req);
endmodule
bind time_update_irq time_update_irq_sva #(.IRQ_PULSE_CYCLES(IRQ_PULSE_CYCLES)) i_sva (
    .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .other_irq_req(other_irq_req),
    .int_out(int_out), .int_oe(int_oe));

// File: irq_line_model.sv
// Host side of the shared interrupt line
`timescale 1ns/1ps
module irq_line_model (
    input  wire int_out,
    input  wire int_oe,
    output wire int_pin_n
);
    // Pull-up holds the line high once released
    assign int_pin_n = int_oe ? int_out : 1'b1;
endmodule

// File: tb.sv
// Self-checking bench for the time update interrupt block
`timescale 1ns/1ps
`include "time_update_irq_consts.vh"
module tb;
    localparam SEC = 20;
    localparam PULSE = 5;
    reg         clk = 1'b0;
    reg         reset_n = 1'b0;
    reg         hsel = 1'b0;
    reg  [31:0] haddr = 32'h0;
    reg  [1:0]  htrans = 2'h0;
    reg         hwrite = 1'b0;
    reg  [31:0] hwdata = 32'h0;
    reg         other_irq_req = 1'b0;
    wire        hreadyout;
    wire [31:0] hrdata;
    wire        int_out;
    wire        int_oe;
    wire        irq;
    wire        int_pin_n;
    integer     n_errors = 0;
    integer     comparisons = 0;
    integer     n;
    reg  [31:0] d;
    time_update_irq #(.SECOND_CYCLES(SEC), .IRQ_PULSE_CYCLES(PULSE)) i_dut (
        .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .other_irq_req(other_irq_req),
        .int_out(int_out), .int_oe(int_oe), .irq(irq));
    irq_line_model i_pin (.int_out(int_out), .int_oe(int_oe), .int_pin_n(int_pin_n));
    initial forever #12.5 clk = ~clk;
    task chk(input [8*8:1] what, input [31:0] exp, input [31:0] got);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("BAD %0s exp %h got %h", what, exp, got);
            end
        end
    endtask
    task xfer(input [7:0] idx, input wr, input [31:0] wd);
        begin
            @(posedge clk);
            hsel <= 1'b1;
            haddr <= {22'h0, idx, 2'h0};
            htrans <= 2'h2;
            hwrite <= wr;
            @(posedge clk);
            while (hreadyout !== 1'b1) @(posedge clk);
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= wd;
            @(posedge clk);
            while (hreadyout !== 1'b1) @(posedge clk);
            d = hrdata;
        end
    endtask
    task rd(input [7:0] idx, input [8*8:1] what, input [31:0] exp);
        begin
            xfer(idx, 1'b0, 32'h0);
            chk(what, exp, d);
        end
    endtask
    task wait_low;
        begin
            n = 0;
            @(negedge clk);
            while (int_pin_n !== 1'b0) begin
                @(negedge clk);
                n = n + 1;
            end
        end
    endtask
    task complete_run;
        begin
            $display("checks %0d mismatches %0d", comparisons, n_errors);
            if (n_errors == 0 && comparisons > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    initial begin
        repeat (3000) @(posedge clk);
        n_errors = n_errors + 1;
        complete_run;
    end
    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        for (n = 0; n < 6; n = n + 1)
            rd((n == 5) ? 8'h20 : 8'h0D + n[7:0], "reset", 32'h0);
        $display("test reset done");
        xfer(`IDX_INTERRUPT_CONTROL, 1'b1, 32'h00);
        xfer(`IDX_INTERRUPT_CONTROL, 1'b1, 32'hFF);
        rd(`IDX_INTERRUPT_CONTROL, "ctl", 32'hFD);
        xfer(`IDX_EXTENSION_CONTROL, 1'b1, 32'hFF);
        rd(`IDX_EXTENSION_CONTROL, "ext", 32'hFF);
        xfer(`IDX_EVENT_FLAGS, 1'b1, 32'h00);
        repeat (45) @(negedge clk);
        rd(`IDX_EVENT_FLAGS, "hold", 32'h00);
        $display("test registers done");
        xfer(`IDX_EXTENSION_CONTROL, 1'b1, 32'h00);
        xfer(`IDX_INTERRUPT_CONTROL, 1'b1, 32'h20);
        wait_low;
        chk("first", 1, n <= SEC);
        n = 0;
        while (int_pin_n === 1'b0) begin
            n = n + 1;
            @(negedge clk);
        end
        chk("pulse", PULSE, n);
        rd(`IDX_IRQ_STATUS, "status", 32'h3);
        xfer(`IDX_EVENT_FLAGS, 1'b1, 32'hFF);
        rd(`IDX_EVENT_FLAGS, "flag", 32'h20);
        wait_low;
        chk("again", 1, n < SEC);
        xfer(`IDX_IRQ_MASK, 1'b1, 32'h1);
        xfer(`IDX_IRQ_STATUS, 1'b1, 32'h3);
        chk("irq clr", 0, irq);
        wait_low;
        xfer(`IDX_EVENT_FLAGS, 1'b1, 32'h00);
        @(negedge clk);
        chk("flag rel", 1, int_pin_n);
        chk("irq set", 1, irq);
        xfer(`IDX_IRQ_STATUS, 1'b1, 32'h1);
        chk("irq off", 0, irq);
        wait_low;
        xfer(`IDX_INTERRUPT_CONTROL, 1'b1, 32'h00);
        @(negedge clk);
        chk("ie rel", 1, int_pin_n);
        $display("test pulse done");
        xfer(`IDX_EVENT_FLAGS, 1'b1, 32'h00);
        n = 0;
        repeat (25) begin
            @(negedge clk);
            if (int_pin_n !== 1'b1)
                n = n + 1;
        end
        chk("quiet", 0, n);
        rd(`IDX_EVENT_FLAGS, "no ie", 32'h20);
        @(posedge clk) other_irq_req <= 1'b1;
        repeat (2) @(negedge clk);
        chk("other", 0, int_pin_n);
        @(posedge clk) other_irq_req <= 1'b0;
        repeat (2) @(negedge clk);
        chk("other", 1, int_pin_n);
        $display("test disable done");
        xfer(`IDX_INTERRUPT_CONTROL, 1'b1, 32'h01);
        xfer(`IDX_EVENT_FLAGS, 1'b1, 32'h00);
        xfer(`IDX_EXTENSION_CONTROL, 1'b1, 32'h20);
        xfer(`IDX_INTERRUPT_CONTROL, 1'b1, 32'h20);
        repeat (1100) @(negedge clk);
        rd(`IDX_EVENT_FLAGS, "minute", 32'h00);
        wait_low;
        chk("minute", 1, n <= 150);
        $display("test minute done");
        complete_run;
    end
endmodule
